// file: pcpt_paged_control_port.sv
// Paged register space reached over I2C or SPI
`timescale 1ns/100ps
`include "pcpt_cfg.svh"
// Contract
// [RQ1] I2C write opens with matching address, ack
// [RQ2] Register byte then data byte, both acked
// [RQ3] Ack every written data byte until stop
// [RQ4] Read: address write, repeated start, read
// [RQ5] Device drives addressed byte after read address
// [RQ6] Keep sending while controller acks
// [RQ7] SPI frame starts at select falling edge
// [RQ8] SPI clock polarity 0, phase 1
// [RQ9] First byte command; data only on write
// [RQ10] Framing restarts only at select falling edge
// [RQ11] Command holds 7-bit address, direction last
// [RQ12] SPI write stores second byte
// [RQ13] SPI read shifts register out second byte
// [RQ14] Sequential addressing while select stays low
// [RQ15] Pages of 128 bytes, page at 0
// [RQ16] Page 0 selected after reset
// [RQ17] Writing register 0 switches page
// [RQ18] Only pages 0, 1 and 3 valid
// [RQ19] Host avoids reserved pages and registers
// [RQ20] Address from strap, or broadcast forced
// [RQ21] I2C writes step to next register
// [RQ22] Detect I2C or SPI from pins
// [RQ23] Partial byte never changes a register
module pcpt_paged_control_port (
    // System
    input wire logic sys_clk,
    input wire logic reset_n,
    // SDA or PICO, open drain when SDA
    input wire logic sda_pico_in,
    output logic sda_out,
    output logic sda_oe,
    // SCL or SCLK, also the link clock
    input wire logic scl_sclk,
    // Address strap or SPI select
    input wire logic select_low_pin,
    // SPI POCI
    output logic poci_out,
    output logic poci_oe,
    // Status
    output logic [7:0] page_select,
    output logic spi_mode
);

    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [2:0] cs_q;
    logic [2:0] req_q;
    logic [1:0] strap_cnt_r;
    logic address_strap_r;
    logic spi_mode_r;
    logic [7:0] page_r;
    logic [7:0] mem_r [0:`PCPT_STORE_DEPTH-1];
    pcpt_pkg::pcpt_i2c_st_t st_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic [6:0] ptr_r;
    logic ack_ph_r;
    logic done_r;
    logic rw_r;
    logic sda_oe_r;
    logic sda_out_r;
    logic poci_oe_r;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic [6:0] dev_addr;
    logic [7:0] i2c_rd;
    logic i2c_wr_en;
    logic spi_wr_en;
    logic wr_en;
    pcpt_pkg::pcpt_wr_t wr;
    // Link domain
    logic [2:0] sp_cnt_r;
    logic sp_first_r;
    logic sp_rw_r;
    logic [6:0] sp_addr_r;
    logic [7:0] sp_sh_r;
    logic [7:0] sp_tx_r;
    logic [7:0] sp_nxt;
    logic [7:0] sp_rd;
    logic sp_req_r;
    logic poci_r;
    pcpt_pkg::pcpt_wr_t sp_wr_r;

    // [RQ18] valid page test
    function automatic logic page_ok(input logic [7:0] pg);
        page_ok = (pg == `PCPT_PAGE_A) || (pg == `PCPT_PAGE_B) ||
                  (pg == `PCPT_PAGE_C);
    endfunction

    // [RQ15] pages mapped into storage
    function automatic logic [8:0] idx(input logic [7:0] pg,
                                        input logic [6:0] a);
        logic [1:0] p;
        p = (pg == `PCPT_PAGE_C) ? 2'h2 : pg[1:0];
        idx = {p, a};
    endfunction

    // [RQ17] register 0 reads the page of every page
    function automatic logic [7:0] rd_byte(input logic [6:0] a);
        if (a == `PCPT_PAGE_SEL_ADDR) begin
            rd_byte = page_r;
        end else if (page_ok(page_r)) begin
            rd_byte = mem_r[idx(page_r, a)];
        end else begin
            rd_byte = 8'h00;
        end
    endfunction

    // Pin and request synchronisers, first stage read only by second
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            cs_q <= 3'h0;
            req_q <= 3'h0;
        end else begin
            scl_q <= {scl_q[1:0], scl_sclk};
            sda_q <= {sda_q[1:0], sda_pico_in};
            cs_q <= {cs_q[1:0], select_low_pin};
            req_q <= {req_q[1:0], sp_req_r};
        end
    end

    always_comb begin
        start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
        stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
        rise = scl_q[1] & ~scl_q[2];
        fall = ~scl_q[1] & scl_q[2];
    end

    // [RQ22] strap caught after release; select edge means SPI
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            strap_cnt_r <= 2'h0;
            address_strap_r <= 1'b0;
            spi_mode_r <= 1'b0;
        end else begin
            if (strap_cnt_r != 2'h3) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
            if (strap_cnt_r == `PCPT_STRAP_WAIT) begin
                address_strap_r <= cs_q[1];
            end
            if (strap_cnt_r == 2'h3 && cs_q[2] && !cs_q[1]) begin
                spi_mode_r <= 1'b1;
            end
        end
    end

    // [RQ20] own address or broadcast address
    always_comb begin
        if (mem_r[`PCPT_BCAST_REG][`PCPT_BCAST_BIT]) begin
            dev_addr = `PCPT_BCAST_ADDR;
        end else begin
            dev_addr = {`PCPT_I2C_ADDR_HI, 1'b0, address_strap_r};
        end
        i2c_rd = rd_byte(ptr_r);
    end

    // [RQ23] writes only on a complete data byte
    always_comb begin
        i2c_wr_en = !spi_mode_r && !start && !stop && fall &&
                    st_r == pcpt_pkg::I_WDAT && done_r && !ack_ph_r;
        spi_wr_en = spi_mode_r && req_q[1] && !req_q[2];
        wr_en = i2c_wr_en || spi_wr_en;
        if (spi_mode_r) begin
            wr = sp_wr_r;
        end else begin
            wr.addr = ptr_r;
            wr.data = sh_r;
        end
    end

    // Register storage and page select
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // [RQ16] page 0 after reset
            page_r <= `PCPT_PAGE_RST;
            for (int i = 0; i < `PCPT_STORE_DEPTH; i++) begin
                mem_r[i] <= `PCPT_STORE_RST;
            end
        end else if (wr_en) begin
            // [RQ17] register 0 of any page sets page
            if (wr.addr == `PCPT_PAGE_SEL_ADDR) begin
                page_r <= wr.data;
            end else if (page_ok(page_r)) begin
                mem_r[idx(page_r, wr.addr)] <= wr.data;
            end
        end
    end

    // I2C target engine
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_r <= pcpt_pkg::I_IDLE;
            bit_cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 7'h00;
            ack_ph_r <= 1'b0;
            done_r <= 1'b0;
            rw_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (spi_mode_r || stop) begin
            st_r <= pcpt_pkg::I_IDLE;
            ack_ph_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (start) begin
            // [RQ4] start or repeated start reopens address
            st_r <= pcpt_pkg::I_DEV;
            bit_cnt_r <= 4'h0;
            ack_ph_r <= 1'b0;
            done_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (st_r)
                pcpt_pkg::I_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                pcpt_pkg::I_DEV, pcpt_pkg::I_REG, pcpt_pkg::I_WDAT: begin
                    if (rise && !ack_ph_r) begin
                        sh_r <= {sh_r[6:0], sda_q[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'h7) begin
                            done_r <= 1'b1;
                        end
                    end
                    if (fall && ack_ph_r) begin
                        sda_oe_r <= 1'b0;
                        ack_ph_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        done_r <= 1'b0;
                        if (st_r == pcpt_pkg::I_DEV && rw_r) begin
                            // [RQ5] first read byte driven
                            st_r <= pcpt_pkg::I_RDAT;
                            sda_oe_r <= !i2c_rd[7];
                            tx_r <= {i2c_rd[6:0], 1'b0};
                            ptr_r <= ptr_r + 7'h1;
                        end else if (st_r == pcpt_pkg::I_DEV) begin
                            st_r <= pcpt_pkg::I_REG;
                        end else begin
                            st_r <= pcpt_pkg::I_WDAT;
                        end
                    end else if (fall && done_r) begin
                        ack_ph_r <= 1'b1;
                        if (st_r == pcpt_pkg::I_DEV) begin
                            // [RQ1] ack only dev_addr, own or broadcast address
                            if (sh_r[7:1] == dev_addr) begin
                                sda_oe_r <= 1'b1;
                                rw_r <= sh_r[0];
                            end else begin
                                st_r <= pcpt_pkg::I_IDLE;
                            end
                        end else if (st_r == pcpt_pkg::I_REG) begin
                            // [RQ2] register byte sets pointer
                            sda_oe_r <= 1'b1;
                            ptr_r <= sh_r[6:0];
                        end else begin
                            // [RQ3] [RQ21] ack, step pointer
                            sda_oe_r <= 1'b1;
                            ptr_r <= ptr_r + 7'h1;
                        end
                    end
                end
                pcpt_pkg::I_RDAT: begin
                    if (rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    if (fall) begin
                        if (bit_cnt_r == 4'h8) begin
                            sda_oe_r <= 1'b0;
                            done_r <= 1'b0;
                            st_r <= pcpt_pkg::I_RACK;
                        end else begin
                            sda_oe_r <= !tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                    end
                end
                pcpt_pkg::I_RACK: begin
                    // [RQ6] next byte on ack, stop on nack
                    if (rise) begin
                        if (sda_q[1]) begin
                            st_r <= pcpt_pkg::I_IDLE;
                        end else begin
                            done_r <= 1'b1;
                        end
                    end
                    if (fall && done_r) begin
                        st_r <= pcpt_pkg::I_RDAT;
                        bit_cnt_r <= 4'h0;
                        done_r <= 1'b0;
                        sda_oe_r <= !i2c_rd[7];
                        tx_r <= {i2c_rd[6:0], 1'b0};
                        ptr_r <= ptr_r + 7'h1;
                    end
                end
            endcase
        end
    end

    // Pin drivers in the system domain
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sda_out_r <= 1'b0;
            poci_oe_r <= 1'b0;
        end else begin
            sda_out_r <= 1'b0;
            poci_oe_r <= spi_mode_r & ~cs_q[1];
        end
    end

    // SPI link domain; select high clears framing
    assign sp_nxt = {sp_sh_r[6:0], sda_pico_in};

    // [RQ7] [RQ8] [RQ10] sample on falling SCLK, frame at select
    always_ff @(negedge scl_sclk or posedge select_low_pin) begin
        if (select_low_pin) begin
            sp_cnt_r <= 3'h0;
            sp_first_r <= 1'b1;
            sp_rw_r <= 1'b0;
            sp_addr_r <= 7'h00;
            sp_sh_r <= 8'h00;
            sp_req_r <= 1'b0;
        end else begin
            sp_sh_r <= sp_nxt;
            sp_cnt_r <= sp_cnt_r + 3'h1;
            if (sp_cnt_r == 3'h3) begin
                sp_req_r <= 1'b0;
            end
            if (sp_cnt_r == 3'h7) begin
                if (sp_first_r) begin
                    // [RQ9] [RQ11] command: address then direction
                    sp_addr_r <= sp_nxt[7:1];
                    sp_rw_r <= sp_nxt[0];
                    sp_first_r <= 1'b0;
                end else begin
                    // [RQ14] sequential address
                    sp_addr_r <= sp_addr_r + 7'h1;
                    if (!sp_rw_r) begin
                        sp_req_r <= 1'b1;
                    end
                end
            end
        end
    end

    // [RQ12] write word held until the next write byte
    always_ff @(negedge scl_sclk) begin
        if (sp_cnt_r == 3'h7 && !sp_first_r && !sp_rw_r) begin
            sp_wr_r.addr <= sp_addr_r;
            sp_wr_r.data <= sp_nxt;
        end
    end

    // Config storage is quasi-static while the port reads it
    always_comb begin
        sp_rd = rd_byte(sp_addr_r);
    end

    // [RQ13] read data shifted out on rising SCLK
    always_ff @(posedge scl_sclk or posedge select_low_pin) begin
        if (select_low_pin) begin
            sp_tx_r <= 8'h00;
            poci_r <= 1'b0;
        end else if (sp_cnt_r == 3'h0 && !sp_first_r && sp_rw_r) begin
            poci_r <= sp_rd[7];
            sp_tx_r <= {sp_rd[6:0], 1'b0};
        end else begin
            poci_r <= sp_tx_r[7];
            sp_tx_r <= {sp_tx_r[6:0], 1'b0};
        end
    end

    assign sda_out = sda_out_r;
    assign sda_oe = sda_oe_r;
    assign poci_out = poci_r;
    assign poci_oe = poci_oe_r;
    assign page_select = page_r;
    assign spi_mode = spi_mode_r;

endmodule

// file: pcpt_cfg.svh
// Constants of the paged control port target
`ifndef PCPT_CFG_SVH
`define PCPT_CFG_SVH
// Fixed upper bits of the I2C target address
`define PCPT_I2C_ADDR_HI 5'h14
// Broadcast target address
`define PCPT_BCAST_ADDR 7'h50
// Broadcast enable: page 0, register 4, bit 1
`define PCPT_BCAST_REG 9'h004
`define PCPT_BCAST_BIT 1
// Page select register and its reset value
`define PCPT_PAGE_SEL_ADDR 7'h00
`define PCPT_PAGE_RST 8'h00
// Valid pages
`define PCPT_PAGE_A 8'h00
`define PCPT_PAGE_B 8'h01
`define PCPT_PAGE_C 8'h03
// Storage: three pages of 128 bytes
`define PCPT_STORE_DEPTH 384
`define PCPT_STORE_RST 8'h00
// Cycles after reset before the strap is caught
`define PCPT_STRAP_WAIT 2'h2
`endif

// file: pcpt_pkg.sv
// Types of the paged control port target
package pcpt_pkg;
    typedef enum logic [5:0] {
        I_IDLE = 6'h01,
        I_DEV  = 6'h02,
        I_REG  = 6'h04,
        I_WDAT = 6'h08,
        I_RDAT = 6'h10,
        I_RACK = 6'h20
    } pcpt_i2c_st_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } pcpt_wr_t;
endpackage

// file: pcpt_host_model.sv
// Host controller model for the shared I2C or SPI pins
`timescale 1ns/100ps
module pcpt_host_model (
    // Pins toward the device
    output logic scl,
    output logic dat,
    output logic sel,
    // Line levels seen back
    input logic sda,
    input logic poci
);
    initial begin
        scl = 1'b1;
        dat = 1'b1;
        sel = 1'b0;
    end
    task start();
        dat = 1'b1;
        #100 scl = 1'b1;
        #100 dat = 1'b0;
        #100 scl = 1'b0;
        #100;
    endtask
    task stop();
        dat = 1'b0;
        #100 scl = 1'b1;
        #100 dat = 1'b1;
        #200;
    endtask
    task i2c_byte(input logic [8:0] tx, input int n,
                  output logic [8:0] rx);
        for (int k = 8; k > 8 - n; k--) begin
            dat = tx[k];
            #100 scl = 1'b1;
            #100 rx[k] = sda;
            #100 scl = 1'b0;
            #100;
        end
    endtask
    // set on rising, sampled on falling
    task spi_byte(input logic [7:0] tx, input int n,
                  output logic [7:0] rx);
        for (int k = 7; k > 7 - n; k--) begin
            scl = 1'b1;
            dat = tx[k];
            #40 scl = 1'b0;
            rx[k] = poci;
            #40;
        end
    endtask
    // lo pulls select low with SCLK low; otherwise select goes high
    task frame(input logic lo);
        if (lo) begin
            scl = 1'b0;
            #103 sel = 1'b0;
            #100;
        end else begin
            #100 sel = 1'b1;
            dat = 1'b1;
            #200;
        end
    endtask
endmodule

// file: pcpt_properties.sv
// Concurrent checks on the control port pins
`timescale 1ns/100ps
module pcpt_properties (
    // System
    input logic sys_clk,
    input logic reset_n,
    // Pins
    input logic sda_out,
    input logic sda_oe,
    input logic scl_sclk,
    input logic select_low_pin,
    input logic poci_out,
    input logic poci_oe,
    // Status
    input logic [7:0] page_select,
    input logic spi_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_held;
        sda_oe [*8];
    endsequence
    a_reset_vals: assert property (
        $rose(reset_n) |-> !spi_mode && !sda_oe && page_select == 8'h00)
        else $error("state not cleared by reset");
    a_sda_low: assert property (!sda_out)
        else $error("sda output not low");
    a_sda_timing: assert property (
        $changed(sda_oe) |-> !scl_sclk && !$past(scl_sclk, 2))
        else $error("sda drive moved outside clock low");
    a_ack_len: assert property ($rose(sda_oe) |-> s_held)
        else $error("sda drive too short");
    a_spi_no_sda: assert property (spi_mode |-> !sda_oe)
        else $error("sda driven in spi mode");
    a_mode_sticky: assert property (spi_mode |=> spi_mode)
        else $error("spi mode dropped");
    a_mode_cause: assert property (
        $rose(spi_mode) |-> !select_low_pin && !$past(select_low_pin))
        else $error("spi mode without select low");
    a_poci_idle: assert property (
        select_low_pin [*5] |-> !poci_oe)
        else $error("poci driven while deselected");
    a_poci_zero: assert property (select_low_pin |-> !poci_out)
        else $error("poci data while deselected");
    a_page_when: assert property (
        $changed(page_select) |->
        (spi_mode ? !select_low_pin : !scl_sclk))
        else $error("page changed outside a write");
endmodule
bind pcpt_paged_control_port pcpt_properties i_props (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .scl_sclk(scl_sclk),
    .select_low_pin(select_low_pin),
    .poci_out(poci_out),
    .poci_oe(poci_oe),
    .page_select(page_select),
    .spi_mode(spi_mode)
);

// file: paged_control_port_target_tb_top.sv
// Testbench for the paged control port target
`timescale 1ns/100ps
module paged_control_port_target_tb_top;
    logic sys_clk, reset_n, scl, dat, sel, sda_oe, sda_out;
    logic poci_out, poci_oe, spi_mode, spi;
    logic [7:0] page_select;
    logic [6:0] dev;
    int miscompares, compares;
    // Open drain with pull-up; undriven poci toggles
    wire sda_line = dat & ~sda_oe;
    wire poci_line = poci_oe ? poci_out : sys_clk;
    pcpt_paged_control_port i_dut (.sys_clk, .reset_n,
        .sda_pico_in(sda_line), .sda_out, .sda_oe, .scl_sclk(scl),
        .select_low_pin(sel), .poci_out, .poci_oe, .page_select,
        .spi_mode);
    pcpt_host_model i_host (.scl, .dat, .sel, .sda(sda_line),
        .poci(poci_line));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task do_reset(input logic strap);
        @(negedge sys_clk);
        reset_n = 1'b0;
        i_host.sel = strap;
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (10) @(negedge sys_clk);
        check(page_select, 8'h00);
    endtask
    task automatic send(input logic [7:0] b);
        logic [8:0] r;
        i_host.i2c_byte({b, 1'b1}, 9, r);
        check({7'h00, r[0]}, 8'h00);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        @(negedge sys_clk);
        if (spi) begin
            i_host.frame(1'b1);
            i_host.spi_byte({a, 1'b0}, 8, q);
            i_host.spi_byte(d, 8, q);
            i_host.frame(1'b0);
        end else begin
            i_host.start();
            send({dev, 1'b0});
            send({1'b0, a});
            send(d);
            i_host.stop();
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [8:0] r;
        logic [7:0] q;
        @(negedge sys_clk);
        if (spi) begin
            i_host.frame(1'b1);
            i_host.spi_byte({a, 1'b1}, 8, q);
            i_host.spi_byte(8'hFF, 8, q);
            i_host.frame(1'b0);
        end else begin
            i_host.start();
            send({dev, 1'b0});
            send({1'b0, a});
            i_host.start();
            send({dev, 1'b1});
            i_host.i2c_byte(9'h1FF, 9, r);
            q = r[8:1];
            i_host.stop();
        end
        check(q, e);
    endtask
    task automatic t_i2c_seq();
        logic [8:0] r;
        i_host.start();
        send({dev, 1'b0});
        send(8'h05);
        for (int k = 0; k < 3; k++)
            send(8'hA1 + 8'h11 * k[7:0]);
        i_host.stop();
        i_host.start();
        send({dev, 1'b0});
        send(8'h05);
        i_host.start();
        send({dev, 1'b1});
        for (int k = 0; k < 3; k++) begin
            i_host.i2c_byte({8'hFF, k == 2}, 9, r);
            check(r[8:1], 8'hA1 + 8'h11 * k[7:0]);
        end
        i_host.stop();
        rd(7'h06, 8'hB2);
        $display("i2c_seq done");
    endtask
    task automatic t_i2c_refuse();
        logic [8:0] r;
        i_host.start();
        i_host.i2c_byte({dev ^ 7'h01, 2'b01}, 9, r);
        check({7'h00, r[0]}, 8'h01);
        i_host.stop();
        i_host.start();
        send({dev, 1'b0});
        send(8'h10);
        i_host.i2c_byte(9'h1FF, 4, r);
        i_host.stop();
        rd(7'h10, 8'h00);
        $display("i2c_refuse done");
    endtask
    task t_pages();
        wr(7'h00, 8'h01);
        check(page_select, 8'h01);
        wr(7'h05, 8'h5A);
        wr(7'h00, 8'h03);
        wr(7'h05, 8'h3C);
        wr(7'h00, 8'h02);
        wr(7'h05, 8'h77);
        rd(7'h05, 8'h00);
        rd(7'h00, 8'h02);
        wr(7'h00, 8'h00);
        rd(7'h05, 8'hA1);
        wr(7'h00, 8'h03);
        rd(7'h05, 8'h3C);
        wr(7'h00, 8'h01);
        rd(7'h05, 8'h5A);
        $display("pages done");
    endtask
    task automatic t_strap();
        logic [8:0] r;
        i_host.start();
        i_host.i2c_byte({7'h50, 2'b01}, 9, r);
        check({7'h00, r[0]}, 8'h01);
        i_host.stop();
        wr(7'h04, 8'h02);
        dev = 7'h50;
        rd(7'h04, 8'h02);
        $display("strap done");
    endtask
    task automatic t_spi();
        logic [7:0] q;
        spi = 1'b1;
        i_host.frame(1'b1);
        i_host.spi_byte(8'h40, 8, q);
        i_host.spi_byte(8'h9E, 8, q);
        i_host.spi_byte(8'h4D, 8, q);
        i_host.frame(1'b0);
        check({7'h00, spi_mode}, 8'h01);
        i_host.frame(1'b1);
        i_host.spi_byte(8'h41, 8, q);
        i_host.spi_byte(8'hFF, 8, q);
        check(q, 8'h9E);
        i_host.spi_byte(8'hFF, 8, q);
        check(q, 8'h4D);
        i_host.frame(1'b0);
        i_host.frame(1'b1);
        i_host.spi_byte(8'h42, 8, q);
        i_host.spi_byte(8'h11, 5, q);
        i_host.frame(1'b0);
        rd(7'h21, 8'h4D);
        wr(7'h7F, 8'hE7);
        rd(7'h7F, 8'hE7);
        wr(7'h00, 8'h03);
        check(page_select, 8'h03);
        $display("spi done");
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #1900000;
        miscompares++;
        end_sim();
    end
    initial begin
        reset_n = 1'b0;
        spi = 1'b0;
        dev = 7'h50;
        miscompares = 0;
        compares = 0;
        do_reset(1'b0);
        t_i2c_seq();
        t_i2c_refuse();
        t_pages();
        dev = 7'h51;
        do_reset(1'b1);
        t_strap();
        t_spi();
        end_sim();
    end
endmodule
